// [rtl/serial_channel_mode_config.sv]
// Serial channel mode registers, CRC engine and channel connection logic
`timescale 1ns/1ps
`include "serial_mode_map.svh"
`default_nettype none
module serial_channel_mode_config
  import serial_mode_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rx_data_line,
  input  wire logic        rx_clock_pin,
  input  wire logic        tx_clock_pin_in,
  output logic             tx_data_line,
  output logic             tx_clock_pin_out,
  output logic             tx_clock_pin_oe,
  input  wire logic        tx_clock_is_output,
  input  wire logic        channel_idle,
  input  wire logic        tx_frame_start,
  input  wire logic        tx_payload_bit,
  input  wire logic        tx_payload_valid,
  input  wire logic        tx_crc_start,
  input  wire logic        tx_char_start,
  input  wire logic        rx_frame_start,
  input  wire logic        rx_frame_end,
  input  wire logic        rx_char_start,
  output logic             tx_take,
  output logic             tx_crc_busy,
  output logic             rx_bit,
  output logic             rx_bit_valid,
  output logic             crc_error_flag,
  output protocol_t        protocol_select,
  output logic             crc_enable,
  output logic [2:0]       stop_half_bits,
  output logic [6:0]       oversample_ratio,
  output logic [1:0]       address_check_mode,
  output logic [3:0]       tx_char_length,
  output logic [3:0]       rx_char_length,
  output logic [1:0]       tx_parity_multiproc_mode,
  output logic [1:0]       rx_parity_multiproc_mode,
  output line_code_t       line_code_select,
  output logic [5:0]       recovery_ratio,
  output connection_t      channel_connection
);
  state_t s;
  state_t next_s;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b, input logic ccitt);
    logic [15:0] r;
    r = {c[14:0], 1'b0};
    if (c[15] ^ b) begin
      r = r ^ (ccitt ? `POLY_CCITT : `POLY_CRC16);
    end
    return r;
  endfunction

  function automatic logic [3:0] char_bits(input logic [1:0] code);
    return 4'h8 - {2'b00, code};
  endfunction

  function automatic logic is_sync(input logic [7:0] m0);
    logic [2:0] p;
    p = m0[`PROTO_MSB:`PROTO_LSB];
    return (p != proto_async) && (p <= proto_bitsync);
  endfunction

  logic        sync_mode;
  logic        bit_mode;
  logic        crc_on;
  logic        ccitt;
  logic [15:0] preset;
  logic        rx_edge;
  logic        tx_edge;
  logic        echo_on;
  logic        loop_on;
  logic        rx_in;
  logic        crc_load;
  logic [15:0] rx_expect;
  logic        chan_cmd;

  // Active copies, not the raw registers, steer the datapath
  assign sync_mode = is_sync(s.act_zero);
  assign bit_mode  = s.act_zero[`PROTO_MSB:`PROTO_LSB] == proto_bitsync;
  assign crc_on    = sync_mode & s.act_zero[`CRC_EN_BIT];
  assign ccitt     = s.act_zero[`POLY_SEL_BIT];
  assign preset    = s.act_zero[`PRESET_SEL_BIT] ? `PRESET_ONES : `PRESET_ZEROS;
  assign echo_on   = s.act_two[`CONN_MSB:`CONN_LSB] == conn_auto_echo;
  assign loop_on   = s.act_two[`CONN_MSB:`CONN_LSB] == conn_local_loop;
  assign rx_edge   = s.rxc_s2 & ~s.rxc_d;
  // Loopback runs the transmitter on the receive clock
  assign tx_edge   = loop_on ? rx_edge : (s.txc_s2 & ~s.txc_d);
  assign rx_in     = loop_on ? s.tx_bit : s.rxd_s2;
  assign crc_load  = tx_crc_start & crc_on & (s.tx_cnt == `CNT_ZERO) & ~echo_on;
  // Complemented FCS leaves a fixed residue instead of zero
  assign rx_expect = bit_mode ? (ccitt ? `RESID_CCITT : `RESID_CRC16) : `RESID_PLAIN;
  assign chan_cmd  = s.wr_pend & (s.addr == `OFS_COMMAND) & (hwdata[7:0] == `CMD_CHANNEL_RESET);

  always_comb begin
    logic [7:0]  m0;
    logic [7:0]  m1;
    logic [7:0]  m2;
    logic [7:0]  rd;
    logic [2:0]  p;
    logic        chan_rst;
    m0 = 8'h00;
    m1 = 8'h00;
    m2 = 8'h00;
    rd = 8'h00;
    p = 3'b000;
    chan_rst = 1'b0;
    next_s = s;
    next_s.rxc_s1 = rx_clock_pin;
    next_s.rxc_s2 = s.rxc_s1;
    next_s.rxc_d = s.rxc_s2;
    next_s.txc_s1 = tx_clock_pin_in;
    next_s.txc_s2 = s.txc_s1;
    next_s.txc_d = s.txc_s2;
    next_s.rxd_s1 = rx_data_line;
    next_s.rxd_s2 = s.rxd_s1;
    next_s.tx_take = 1'b0;
    next_s.rx_valid = 1'b0;
    next_s.wr_pend = 1'b0;
    // Write data phase
    if (s.wr_pend) begin
      unique case (s.addr)
        `OFS_MODE_ZERO:  next_s.mode_zero = hwdata[7:0];
        `OFS_MODE_ONE:   next_s.mode_one = hwdata[7:0];
        `OFS_MODE_TWO:   next_s.mode_two = hwdata[7:0];
        `OFS_COMMAND:    chan_rst = hwdata[7:0] == `CMD_CHANNEL_RESET;
        `OFS_STATUS_TWO: begin
          if (hwdata[`STATUS_CRC_ERR_BIT]) begin
            next_s.crc_err = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (chan_rst) begin
      next_s.mode_zero = `MODE_RESET;
      next_s.mode_one = `MODE_RESET;
      next_s.mode_two = `MODE_RESET;
      next_s.act_zero = `MODE_RESET;
      next_s.act_two = `MODE_RESET;
      next_s.act_ovs = 2'b00;
      next_s.tx_len = 2'b00;
      next_s.tx_par = 2'b00;
      next_s.rx_len = 2'b00;
      next_s.rx_par = 2'b00;
      next_s.tx_cnt = `CNT_ZERO;
      next_s.rx_fill = `CNT_ZERO;
    end else if (channel_idle) begin
      next_s.act_zero = next_s.mode_zero;
      next_s.act_two = next_s.mode_two;
      next_s.act_ovs = next_s.mode_one[`OVS_MSB:`OVS_LSB];
    end
    if (tx_char_start) begin
      next_s.tx_len = next_s.mode_one[`TXLEN_MSB:`TXLEN_LSB];
      next_s.tx_par = next_s.mode_one[`PAR_MSB:`PAR_LSB];
    end
    if (rx_char_start) begin
      next_s.rx_len = next_s.mode_one[`RXLEN_MSB:`RXLEN_LSB];
      next_s.rx_par = next_s.mode_one[`PAR_MSB:`PAR_LSB];
    end
    // Address phase; read sees a write made in the cycle before
    if (hready & hsel & htrans[`HTRANS_ACTIVE_BIT]) begin
      next_s.addr = haddr[7:0];
      next_s.wr_pend = hwrite;
      p = next_s.mode_zero[`PROTO_MSB:`PROTO_LSB];
      m0 = (p == proto_async) ? `RD_MASK0_ASYNC : `RD_MASK0_SYNC;
      m1 = (p == proto_async) ? `RD_MASK1_ASYNC : (p == proto_bitsync) ? `RD_MASK1_BIT : `RD_MASK1_BYTE;
      m2 = (p == proto_async) ? `RD_MASK2_ASYNC : `RD_MASK2_SYNC;
      unique case (haddr[7:0])
        `OFS_MODE_ZERO:  rd = next_s.mode_zero & m0;
        `OFS_MODE_ONE:   rd = next_s.mode_one & m1;
        `OFS_MODE_TWO:   rd = next_s.mode_two & m2;
        `OFS_STATUS_TWO: rd = {7'h00, next_s.crc_err};
        default:         rd = 8'h00;
      endcase
      next_s.hrdata = {24'h000000, rd};
    end
    // Transmitter
    if (tx_frame_start) begin
      next_s.tx_crc = preset;
    end
    if (crc_load) begin
      next_s.tx_shift = bit_mode ? ~s.tx_crc : s.tx_crc;
      next_s.tx_cnt = `CRC_BITS;
    end else if (tx_edge & ~echo_on) begin
      if (s.tx_cnt != `CNT_ZERO) begin
        next_s.tx_bit = s.tx_shift[15];
        next_s.tx_shift = {s.tx_shift[14:0], 1'b0};
        next_s.tx_cnt = s.tx_cnt - `CNT_ONE;
      end else if (tx_payload_valid) begin
        next_s.tx_bit = tx_payload_bit;
        next_s.tx_take = 1'b1;
        if (crc_on) begin
          next_s.tx_crc = crc_step(next_s.tx_crc, tx_payload_bit, ccitt);
        end
      end else begin
        next_s.tx_bit = 1'b1;
      end
    end
    if (echo_on | loop_on) begin
      next_s.tx_line = s.rxd_s2;
    end else begin
      next_s.tx_line = next_s.tx_bit;
    end
    next_s.txc_out = (echo_on | loop_on) & s.rxc_s2;
    next_s.txc_oe = (echo_on | loop_on) & tx_clock_is_output;
    // Receiver
    if (rx_frame_start) begin
      next_s.rx_crc = preset;
      next_s.rx_fill = `CNT_ZERO;
    end else if (rx_edge) begin
      if (crc_on) begin
        next_s.rx_crc = crc_step(s.rx_crc, rx_in, ccitt);
      end
      if (crc_on & bit_mode) begin
        // Last sixteen bits of a frame stay in the delay line and are dropped
        next_s.rx_dly = {s.rx_dly[14:0], rx_in};
        if (s.rx_fill == `CRC_BITS) begin
          next_s.rx_bit = s.rx_dly[15];
          next_s.rx_valid = 1'b1;
        end else begin
          next_s.rx_fill = s.rx_fill + `CNT_ONE;
        end
      end else begin
        next_s.rx_bit = rx_in;
        next_s.rx_valid = 1'b1;
      end
    end
    // Set after the status-write clear so an error in that cycle survives; channel reset clears last and wins
    if (rx_frame_end & crc_on & (s.rx_crc != rx_expect)) begin
      next_s.crc_err = 1'b1;
    end
    if (chan_rst) begin
      next_s.crc_err = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata           = s.hrdata;
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign tx_data_line     = s.tx_line;
  assign tx_clock_pin_out = s.txc_out;
  assign tx_clock_pin_oe  = s.txc_oe;
  assign tx_take          = s.tx_take;
  assign tx_crc_busy      = s.tx_cnt != `CNT_ZERO;
  assign rx_bit           = s.rx_bit;
  assign rx_bit_valid     = s.rx_valid;
  assign crc_error_flag   = s.crc_err;
  assign protocol_select  = protocol_t'(s.act_zero[`PROTO_MSB:`PROTO_LSB]);
  assign crc_enable       = crc_on;
  assign stop_half_bits   = sync_mode ? 3'h0 : 3'h2 + {1'b0, s.act_zero[`STOP_MSB:`STOP_LSB]};
  assign oversample_ratio = (sync_mode || s.act_ovs == 2'b00) ? 7'h01 : 7'h08 << s.act_ovs;
  assign address_check_mode = bit_mode ? s.act_ovs : 2'b00;
  assign tx_char_length   = char_bits(s.tx_len);
  assign rx_char_length   = char_bits(s.rx_len);
  assign tx_parity_multiproc_mode = sync_mode ? 2'b00 : s.tx_par;
  assign rx_parity_multiproc_mode = sync_mode ? 2'b00 : s.rx_par;
  // Async always NRZ; reserved codes flagged rather than guessed
  assign line_code_select = !sync_mode ? code_nrz :
    (!s.act_two[`FAMILY_BIT] && s.act_two[`CODE_MSB]) ? code_reserved :
    (s.act_two[`CODE_MSB:`CODE_LSB] == 2'b11) ? code_reserved :
    line_code_t'({s.act_two[`FAMILY_BIT], s.act_two[`CODE_MSB:`CODE_LSB]});
  assign recovery_ratio   = (!sync_mode || s.act_two[`RATIO_MSB:`RATIO_LSB] == 2'b11) ? 6'h00 :
    6'h08 << s.act_two[`RATIO_MSB:`RATIO_LSB];
  assign channel_connection = connection_t'(s.act_two[`CONN_MSB:`CONN_LSB]);

  sequence s_crc_load;
    crc_load;
  endsequence
  sequence s_bad_frame;
    rx_frame_end && crc_on && (s.rx_crc != rx_expect) && !chan_cmd;
  endsequence

  a_crc_err_set: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_bad_frame |=> crc_error_flag) else $error("crc error not flagged");
  a_fcs_strip: assert property (@(posedge core_clk) disable iff (!rst_b)
    (rx_edge && crc_on && bit_mode && !rx_frame_start && s.rx_fill != `CRC_BITS) |=> !rx_bit_valid)
    else $error("fcs bit passed");
  a_crc_plain: assert property (@(posedge core_clk) disable iff (!rst_b)
    (s_crc_load and !bit_mode) |=> s.tx_shift == $past(s.tx_crc) && s.tx_cnt == `CRC_BITS)
    else $error("byte crc wrong");
  a_crc_compl: assert property (@(posedge core_clk) disable iff (!rst_b)
    (s_crc_load and bit_mode) |=> s.tx_shift == ~$past(s.tx_crc)) else $error("bit crc not complemented");
  a_stop_mid: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!sync_mode && s.act_zero[`STOP_MSB:`STOP_LSB] == 2'b01) |-> stop_half_bits == 3'h3)
    else $error("stop length wrong");
  a_msb_first: assert property (@(posedge core_clk) disable iff (!rst_b)
    (tx_edge && !echo_on && !crc_load && s.tx_cnt != `CNT_ZERO) |=> s.tx_bit == $past(s.tx_shift[15]))
    else $error("crc not msb first");
  a_tx_len_next: assert property (@(posedge core_clk) disable iff (!rst_b)
    (tx_char_start && !s.wr_pend) |=> s.tx_len == $past(s.mode_one[`TXLEN_MSB:`TXLEN_LSB]))
    else $error("tx length not taken");
  a_echo_line: assert property (@(posedge core_clk) disable iff (!rst_b)
    (echo_on ##1 echo_on) |-> tx_data_line == $past(s.rxd_s2)) else $error("echo missing");
  a_echo_no_tx: assert property (@(posedge core_clk) disable iff (!rst_b)
    echo_on [*2] |-> !tx_take) else $error("transmit in echo");
  a_chan_reset: assert property (@(posedge core_clk) disable iff (!rst_b)
    (s.wr_pend && s.addr == `OFS_COMMAND && hwdata[7:0] == `CMD_CHANNEL_RESET)
    |=> s.mode_zero == `MODE_RESET && s.mode_one == `MODE_RESET && s.mode_two == `MODE_RESET)
    else $error("channel reset missed");
  a_rx_preset: assert property (@(posedge core_clk) disable iff (!rst_b)
    rx_frame_start |=> s.rx_crc == $past(preset))
    else $error("rx crc preset wrong");
  a_fcs_release: assert property (@(posedge core_clk) disable iff (!rst_b)
    (rx_edge && crc_on && bit_mode && !rx_frame_start && s.rx_fill == `CRC_BITS)
    |=> rx_bit_valid && rx_bit == $past(s.rx_dly[15]))
    else $error("delayed bit not released");
  a_echo_clk: assert property (@(posedge core_clk) disable iff (!rst_b)
    (echo_on && tx_clock_is_output)
    |=> tx_clock_pin_oe && tx_clock_pin_out == $past(s.rxc_s2))
    else $error("echo tx clock wrong");
  a_clk_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!echo_on && !loop_on) |=> !tx_clock_pin_oe && !tx_clock_pin_out)
    else $error("tx clock driven in full duplex");
  a_loop_feed: assert property (@(posedge core_clk) disable iff (!rst_b)
    (loop_on && rx_edge && !rx_frame_start && !(crc_on && bit_mode))
    |=> rx_bit_valid && rx_bit == $past(s.tx_bit))
    else $error("loopback bit lost");
  a_loop_clock: assert property (@(posedge core_clk) disable iff (!rst_b)
    (loop_on && rx_edge && !crc_load && s.tx_cnt == `CNT_ZERO && tx_payload_valid)
    |=> tx_take)
    else $error("loopback tx not clocked");
  a_idle_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!channel_idle && !chan_cmd) |=> $stable(s.act_two) && $stable(s.act_zero))
    else $error("active mode changed while busy");
  a_rd_reserved: assert property (@(posedge core_clk) disable iff (!rst_b)
    (hready && hsel && htrans[`HTRANS_ACTIVE_BIT] && haddr[7:0] == `OFS_MODE_TWO && !s.wr_pend
     && s.mode_zero[`PROTO_MSB:`PROTO_LSB] == proto_async)
    |=> hrdata[7:2] == 6'h00)
    else $error("reserved mode bits read back");
endmodule
`default_nettype wire

// [rtl/serial_mode_map.svh]
// Register offsets, field positions and constants of the serial channel mode block
`ifndef SERIAL_MODE_MAP_SVH
`define SERIAL_MODE_MAP_SVH
`define OFS_MODE_ZERO      8'h00
`define OFS_MODE_ONE       8'h04
`define OFS_MODE_TWO       8'h08
`define OFS_COMMAND        8'h0C
`define OFS_STATUS_TWO     8'h10
`define MODE_RESET         8'h00
`define CMD_CHANNEL_RESET  8'h01
`define HTRANS_ACTIVE_BIT  1
`define PROTO_MSB          7
`define PROTO_LSB          5
`define CRC_EN_BIT         2
`define POLY_SEL_BIT       1
`define PRESET_SEL_BIT     0
`define STOP_MSB           1
`define STOP_LSB           0
`define OVS_MSB            7
`define OVS_LSB            6
`define TXLEN_MSB          5
`define TXLEN_LSB          4
`define RXLEN_MSB          3
`define RXLEN_LSB          2
`define PAR_MSB            1
`define PAR_LSB            0
`define FAMILY_BIT         7
`define CODE_MSB           6
`define CODE_LSB           5
`define RATIO_MSB          4
`define RATIO_LSB          3
`define CONN_MSB           1
`define CONN_LSB           0
`define RD_MASK0_ASYNC     8'hF3
`define RD_MASK0_SYNC      8'hF7
`define RD_MASK1_ASYNC     8'hFF
`define RD_MASK1_BYTE      8'h00
`define RD_MASK1_BIT       8'hC0
`define RD_MASK2_ASYNC     8'h03
`define RD_MASK2_SYNC      8'hFB
`define STATUS_CRC_ERR_BIT 0
`define POLY_CRC16         16'h8005
`define POLY_CCITT         16'h1021
`define RESID_CRC16        16'h800D
`define RESID_CCITT        16'h1D0F
`define RESID_PLAIN        16'h0000
`define PRESET_ONES        16'hFFFF
`define PRESET_ZEROS       16'h0000
`define CRC_BITS           5'h10
`define CNT_ZERO           5'h00
`define CNT_ONE            5'h01
`endif

// [rtl/serial_mode_pkg.sv]
// Types shared by the serial channel mode block
package serial_mode_pkg;
  typedef enum logic [2:0] {
    proto_async    = 3'b000,
    proto_mono     = 3'b001,
    proto_bisync   = 3'b010,
    proto_extsync  = 3'b011,
    proto_bitsync  = 3'b100,
    proto_res5     = 3'b101,
    proto_res6     = 3'b110,
    proto_res7     = 3'b111
  } protocol_t;

  typedef enum logic [1:0] {
    conn_full_duplex = 2'b00,
    conn_auto_echo   = 2'b01,
    conn_reserved    = 2'b10,
    conn_local_loop  = 2'b11
  } connection_t;

  typedef enum logic [2:0] {
    code_nrz        = 3'b000,
    code_nrzi       = 3'b001,
    code_manchester = 3'b100,
    code_fm1        = 3'b101,
    code_fm0        = 3'b110,
    code_reserved   = 3'b111
  } line_code_t;

  typedef struct packed {
    logic [7:0]  mode_zero;
    logic [7:0]  mode_one;
    logic [7:0]  mode_two;
    logic [7:0]  act_zero;
    logic [1:0]  act_ovs;
    logic [7:0]  act_two;
    logic [1:0]  tx_len;
    logic [1:0]  tx_par;
    logic [1:0]  rx_len;
    logic [1:0]  rx_par;
    logic        wr_pend;
    logic [7:0]  addr;
    logic [31:0] hrdata;
    logic        rxc_s1;
    logic        rxc_s2;
    logic        rxc_d;
    logic        txc_s1;
    logic        txc_s2;
    logic        txc_d;
    logic        rxd_s1;
    logic        rxd_s2;
    logic [15:0] tx_crc;
    logic [15:0] tx_shift;
    logic [4:0]  tx_cnt;
    logic        tx_bit;
    logic        tx_line;
    logic        tx_take;
    logic        txc_out;
    logic        txc_oe;
    logic [15:0] rx_crc;
    logic [15:0] rx_dly;
    logic [4:0]  rx_fill;
    logic        rx_bit;
    logic        rx_valid;
    logic        crc_err;
  } state_t;
endpackage

// [verif/line_station.sv]
// Far-end station model: drives the receive line and clock, clocks and captures the transmit line
`timescale 1ns/1ps
`default_nettype none
module line_station (
  input  wire logic tx_data_line,
  input  wire logic tx_clock_pin_out,
  input  wire logic tx_clock_pin_oe,
  output logic      rx_data_line,
  output logic      rx_clock_pin,
  output logic      tx_clock_pin_in
);
  logic        tx_drive = 1'h0;
  logic [15:0] seen     = 16'h0000;
  logic [15:0] echo     = 16'h0000;
  initial begin
    rx_data_line = 1'h0;
    rx_clock_pin = 1'h0;
  end
  // Pin level: the block wins while it drives the pin
  assign tx_clock_pin_in = tx_clock_pin_oe ? tx_clock_pin_out : tx_drive;
  // Clock stands low outside frames; bits go most significant first
  task automatic rx_bits(input logic [15:0] v, input int n);
    #20;
    for (int i = n - 1; i >= 0; i--) begin
      rx_data_line = v[i];
      #400;
      echo = {echo[14:0], tx_data_line};
      rx_clock_pin = 1'h1;
      #400;
      rx_clock_pin = 1'h0;
    end
    // Released line flips so a stale level cannot pass for data
    rx_data_line = ~rx_data_line;
  endtask
  // Sample late in the bit: sync and register delay sit well inside it
  task automatic tx_bits(input int n);
    #20;
    for (int i = 0; i < n; i++) begin
      tx_drive = 1'h1;
      #400;
      tx_drive = 1'h0;
      #380;
      seen = {seen[14:0], tx_data_line};
      #20;
    end
  endtask
endmodule
`default_nettype wire

// [verif/serial_channel_mode_config_test.sv]
// Self-checking bench for the serial channel mode block
`timescale 1ns/1ps
`include "serial_mode_map.svh"
`default_nettype none
module serial_channel_mode_config_test;
  import serial_mode_pkg::*;
  logic        core_clk, rst_b = 1'h0, hsel = 1'h0, hwrite = 1'h0, hready, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        tx_clock_is_output = 1'h0, channel_idle = 1'h1, pon = 1'h0;
  logic [5:0]  pv = 6'h00;
  logic [7:0]  pbyte = 8'h00;
  logic [3:0]  pidx = 4'h0;
  logic [15:0] rxv = 16'h0000;
  logic        rx_data_line, rx_clock_pin, tx_clock_pin_in, tx_data_line, tx_clock_pin_out, tx_clock_pin_oe;
  logic        tx_frame_start, tx_payload_bit, tx_payload_valid, tx_crc_start, tx_char_start;
  logic        rx_frame_start, rx_frame_end, rx_char_start, tx_take, tx_crc_busy, rx_bit, rx_bit_valid;
  logic        crc_error_flag, crc_enable;
  protocol_t   protocol_select;
  logic [2:0]  stop_half_bits;
  logic [6:0]  oversample_ratio;
  logic [1:0]  address_check_mode, tx_parity_multiproc_mode, rx_parity_multiproc_mode;
  logic [3:0]  tx_char_length, rx_char_length;
  line_code_t  line_code_select;
  logic [5:0]  recovery_ratio;
  connection_t channel_connection;
  int          fails = 0, compares = 0, takes = 0, rxn = 0, ckn = 0;

  assign hready = hreadyout;
  assign {rx_char_start, rx_frame_end, rx_frame_start, tx_crc_start, tx_char_start, tx_frame_start} = pv;
  assign tx_payload_valid = pon && (pidx < 4'h8);
  assign tx_payload_bit = pbyte[3'(4'h7 - pidx)];

  serial_channel_mode_config dut (
    .core_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
    .hresp, .rx_data_line, .rx_clock_pin, .tx_clock_pin_in, .tx_data_line, .tx_clock_pin_out,
    .tx_clock_pin_oe, .tx_clock_is_output, .channel_idle, .tx_frame_start, .tx_payload_bit,
    .tx_payload_valid, .tx_crc_start, .tx_char_start, .rx_frame_start, .rx_frame_end, .rx_char_start,
    .tx_take, .tx_crc_busy, .rx_bit, .rx_bit_valid, .crc_error_flag, .protocol_select, .crc_enable,
    .stop_half_bits, .oversample_ratio, .address_check_mode, .tx_char_length, .rx_char_length,
    .tx_parity_multiproc_mode, .rx_parity_multiproc_mode, .line_code_select, .recovery_ratio,
    .channel_connection
  );
  line_station line (.tx_data_line, .tx_clock_pin_out, .tx_clock_pin_oe, .rx_data_line, .rx_clock_pin,
                     .tx_clock_pin_in);

  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (tx_take === 1'h1) begin
      pidx <= pidx + 4'h1;
      takes <= takes + 1;
    end
    if (rx_bit_valid === 1'h1) begin
      rxn <= rxn + 1;
      rxv <= {rxv[14:0], rx_bit};
    end
  end
  always @(posedge tx_clock_pin_out) ckn <= ckn + 1;

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wait_ready;
    @(posedge core_clk);
    while (hready !== 1'h1) begin
      @(posedge core_clk);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'h1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'h0, a, 32'h00000000, q);
    chk(what, q, exp);
  endtask
  task automatic pulse(input int k);
    pv[k] <= 1'h1;
    @(posedge core_clk);
    pv[k] <= 1'h0;
    @(posedge core_clk);
  endtask
  function automatic logic [15:0] crc_of(input logic [7:0] b, input logic poly, input logic pre);
    logic [15:0] c;
    logic        f;
    c = pre ? 16'hFFFF : 16'h0000;
    for (int i = 7; i >= 0; i--) begin
      f = c[15] ^ b[i];
      c = {c[14:0], 1'h0} ^ (f ? (poly ? `POLY_CCITT : `POLY_CRC16) : 16'h0000);
    end
    return c;
  endfunction
  task automatic close_out;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Whole run is about 3600 cycles; over five times that means a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    close_out();
  end

  initial begin
    logic [31:0] q;
    logic [15:0] e;
    logic [7:0]  v;
    logic        b;
    int          c, t0;
    void'($urandom(99355));
    repeat (5) @(posedge core_clk);
    rst_b <= 1'h1;
    @(posedge core_clk);
    for (c = 0; c < 5; c++) if (c != 3) rchk("reset", 8'(c * 4), 0);
    $display("test reset values done");
    for (c = 0; c < 4; c++) begin
      v = {3'h0, 3'($urandom), 2'(c)};
      bus(1'h1, `OFS_MODE_ZERO, 32'(v), q);
      bus(1'h1, `OFS_MODE_ONE, {24'h0, {4{2'(c)}}}, q);
      pulse(1);
      pulse(5);
      chk("stop", 32'(stop_half_bits), c + 2);
      chk("ovs", 32'(oversample_ratio), c == 0 ? 1 : 8 << c);
      chk("txlen", 32'(tx_char_length), 8 - c);
      chk("rxlen", 32'(rx_char_length), 8 - c);
      chk("txpar", 32'(tx_parity_multiproc_mode), c);
      chk("rxpar", 32'(rx_parity_multiproc_mode), c);
      chk("proto", 32'(protocol_select), 32'(proto_async));
      rchk("m0async", `OFS_MODE_ZERO, 32'(v & 8'hF3));
    end
    bus(1'h1, `OFS_MODE_ONE, 32'h0, q);
    chk("txlen_hold", 32'(tx_char_length), 5);
    pulse(1);
    chk("txlen_next", 32'(tx_char_length), 8);
    $display("test async fields done");
    bus(1'h1, `OFS_MODE_ZERO, 32'h0000008C, q);
    rchk("m0sync", `OFS_MODE_ZERO, 32'h00000084);
    chk("crc_en", 32'(crc_enable), 1);
    chk("proto", 32'(protocol_select), 32'(proto_bitsync));
    for (c = 0; c < 8; c++) begin
      bus(1'h1, `OFS_MODE_TWO, {24'h0, 3'(c), 2'(c), 3'h4}, q);
      bus(1'h1, `OFS_MODE_ONE, {24'h0, 2'(c), 6'h3F}, q);
      repeat (2) @(posedge core_clk);
      chk("code", 32'(line_code_select), (c[2] ? c[1:0] != 2'h3 : !c[1]) ? c : 7);
      chk("ratio", 32'(recovery_ratio), c[1:0] == 2'h3 ? 0 : 8 << c[1:0]);
      chk("addr", 32'(address_check_mode), c[1:0]);
      rchk("m2sync", `OFS_MODE_TWO, {24'h0, 3'(c), 2'(c), 3'h0});
      rchk("m1bit", `OFS_MODE_ONE, {24'h0, 2'(c), 6'h00});
    end
    $display("test sync fields done");
    for (c = 0; c < 8; c++) begin
      b = c[0] ^ c[1];
      bus(1'h1, `OFS_MODE_ZERO, {24'h0, (c[2] ? 3'h4 : 3'(c % 3 + 1)), 3'h1, 2'(c)}, q);
      if (!c[2]) rchk("m1byte", `OFS_MODE_ONE, 0);
      pbyte <= 8'($urandom);
      pidx <= 4'h0;
      pon <= 1'h1;
      pulse(0);
      line.tx_bits(8);
      @(posedge core_clk);
      pulse(2);
      line.tx_bits(16);
      @(posedge core_clk);
      e = crc_of(pbyte, c[1], c[0]) ^ (c[2] ? 16'hFFFF : 16'h0000);
      chk("tx_crc", 32'(line.seen), 32'(e));
      chk("busy", 32'(tx_crc_busy), 0);
      t0 = rxn;
      pulse(3);
      line.rx_bits({8'h00, pbyte}, 8);
      line.rx_bits(e ^ 16'(b), 16);
      repeat (2) @(posedge core_clk);
      pulse(4);
      chk("crc_err", 32'(crc_error_flag), 32'(b));
      chk("rx_count", rxn - t0, c[2] ? 8 : 24);
      rchk("st2", `OFS_STATUS_TWO, 32'(b));
      bus(1'h1, `OFS_STATUS_TWO, 32'h1, q);
      rchk("st2clr", `OFS_STATUS_TWO, 0);
    end
    $display("test crc done");
    bus(1'h1, `OFS_MODE_ZERO, 32'h24, q);
    channel_idle <= 1'h0;
    bus(1'h1, `OFS_MODE_TWO, 32'h01, q);
    repeat (2) @(posedge core_clk);
    chk("conn_hold", 32'(channel_connection), 32'(conn_full_duplex));
    channel_idle <= 1'h1;
    tx_clock_is_output <= 1'h1;
    repeat (2) @(posedge core_clk);
    chk("conn", 32'(channel_connection), 32'(conn_auto_echo));
    e = 16'($urandom);
    t0 = takes;
    c = ckn;
    pidx <= 4'h0;
    pon <= 1'h1;
    pulse(2);
    chk("echo_busy", 32'(tx_crc_busy), 0);
    line.rx_bits(e, 16);
    @(posedge core_clk);
    chk("echo", 32'(line.echo), 32'(e));
    chk("echo_take", takes - t0, 0);
    chk("echo_clk", ckn - c, 16);
    chk("oe", 32'(tx_clock_pin_oe), 1);
    tx_clock_is_output <= 1'h0;
    repeat (2) @(posedge core_clk);
    chk("oe_off", 32'(tx_clock_pin_oe), 0);
    $display("test echo done");
    bus(1'h1, `OFS_MODE_TWO, 32'h03, q);
    pbyte <= 8'($urandom);
    pidx <= 4'h0;
    t0 = takes;
    e = 16'($urandom);
    line.rx_bits(e, 8);
    repeat (2) @(posedge core_clk);
    chk("loop_take", takes - t0, 8);
    chk("loop_rx", 32'(rxv[6:0]), 32'(pbyte[7:1]));
    chk("loop_echo", 32'(line.echo[7:0]), 32'(e[7:0]));
    $display("test loopback done");
    bus(1'h1, `OFS_COMMAND, 32'(`CMD_CHANNEL_RESET), q);
    for (c = 0; c < 3; c++) rchk("chreset", 8'(c * 4), 0);
    $display("test channel reset done");
    close_out();
  end
endmodule
`default_nettype wire
